// ===== hw/sfm_pkg.sv
// package: constants and types of the servo fault manager
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sfm_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLR_MIN_MS = 120;
    localparam int unsigned CLR_CYCLES = CLR_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned OVL_WAIT_S = 10;
    localparam int unsigned OVL_CYCLES = OVL_WAIT_S * CLK_HZ;
    localparam int unsigned HIST_DEPTH = 8;

    // register byte offsets on the avalon slave
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h08;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h0c;
    localparam logic [5:0] OFS_OVL_ACC = 6'h10;
    localparam logic [5:0] OFS_HIST_CNT = 6'h14;
    localparam logic [5:0] OFS_HIST_BASE = 6'h20;

    // reset values and field positions
    localparam logic CTRL_RST = 1'b0;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    localparam int unsigned IRQ_BIT_FAULT = 0;
    localparam int unsigned IRQ_BIT_CLEARED = 1;
    localparam int unsigned ST_BIT_ACTIVE = 0;
    localparam int unsigned ST_BIT_LOCKED = 1;
    localparam int unsigned ST_BIT_OVL_OK = 2;
    localparam int unsigned ST_SUB_LSB = 8;
    localparam int unsigned ST_MAIN_LSB = 16;

    // main codes that change the block's own behaviour
    localparam logic [7:0] MAIN_OVERLOAD = 8'h10;
    localparam logic [7:0] MAIN_MOTOR_RECOG = 8'h5f;

    typedef struct packed {
        logic [7:0] main;
        logic [7:0] sub;
    } sfm_code_t;

    typedef struct packed {
        logic hist;
        logic clr;
        logic imm;
    } sfm_attr_t;

    // whole state of the manager, registered in one process
    typedef struct packed {
        logic [2:0] clr_sync;
        logic [2:0] en_sync;
        logic clr_f;
        logic en_f;
        logic [22:0] clr_cnt;
        logic active;
        logic locked;
        logic imm;
        sfm_code_t code;
        logic [28:0] ovl_cnt;
        logic [15:0] ovl_acc;
        logic [HIST_DEPTH-1:0][15:0] hist;
        logic [2:0] hist_ptr;
        logic [3:0] hist_cnt;
        logic drive_en;
        logic ctrl_seq;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
    } sfm_state_t;
endpackage

// ===== hw/sfm_fault_manager.sv
// module: servo drive protective fault manager with avalon-mm register slave
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sfm_fault_manager
    import sfm_pkg::*;
#(
    parameter logic [22:0] CLR_CYC = 23'(CLR_CYCLES),
    parameter logic [28:0] OVL_CYC = 29'(OVL_CYCLES)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic fault_valid,
    input wire sfm_code_t fault_code,
    input wire logic overload_excess,
    input wire logic fault_clear_input,
    input wire logic drive_enable_req,
    output logic fault_output,
    output logic motor_stop,
    output logic immediate_stop,
    output logic drive_enable,
    output sfm_code_t display_code,
    output logic irq,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    //--------------------------------------------------------------------------
    // state and next state
    //--------------------------------------------------------------------------
    sfm_state_t st_r;
    sfm_state_t st_nxt;
    sfm_attr_t in_attr;
    logic clr_fire;
    logic ovl_ok;
    logic req;

    // attribute lookup per code; unlisted codes are history only
    function automatic sfm_attr_t sfm_attr(input sfm_code_t c);
        sfm_attr_t a;
        a = '{hist: 1'b1, clr: 1'b0, imm: 1'b0};
        case (c.main)
            8'h0b, 8'h0d, 8'h1e, 8'h26, 8'h57: a = '{1'b0, 1'b1, 1'b0};
            8'h0c, 8'h10, 8'h1d, 8'h22, 8'h28, 8'h2a: a = '{1'b1, 1'b1, 1'b0};
            8'h0f: a = '{1'b1, 1'b0, 1'b1};
            8'h12: a = (c.sub == 8'h00) ? '{1'b1, 1'b0, 1'b1} : '{1'b1, 1'b0, 1'b0};
            8'h18, 8'h19, 8'h1b, 8'h1c, 8'h27: a = '{1'b1, 1'b1, 1'b1};
            8'h1a: a = (c.sub == 8'h00) ? '{1'b1, 1'b1, 1'b1} : '{1'b1, 1'b1, 1'b0};
            8'h24, 8'h25, 8'h5f: a = '{1'b0, 1'b0, 1'b0};
            default: a = '{1'b1, 1'b0, 1'b0};
        endcase
        return a;
    endfunction

    assign in_attr = sfm_attr(fault_code);
    assign req = avs_read | avs_write;
    // overload wait satisfied, other codes never wait
    assign ovl_ok = (st_r.code.main != MAIN_OVERLOAD) || (st_r.ovl_cnt == OVL_CYC);
    // fires once, on the cycle the filtered input completes its hold time
    assign clr_fire = st_r.clr_f && (st_r.clr_cnt == CLR_CYC - 23'h0001);

    //--------------------------------------------------------------------------
    // next-state logic
    //--------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        // pin synchronisers; only stages 1 and 2 are compared
        st_nxt.clr_sync = {st_r.clr_sync[1:0], fault_clear_input};
        st_nxt.en_sync = {st_r.en_sync[1:0], drive_enable_req};
        if (st_r.clr_sync[1] == st_r.clr_sync[2]) begin
            st_nxt.clr_f = st_r.clr_sync[2];
        end
        if (st_r.en_sync[1] == st_r.en_sync[2]) begin
            st_nxt.en_f = st_r.en_sync[2];
        end

        // hold counter saturates, so a long press clears only once
        if (!st_r.clr_f) begin
            st_nxt.clr_cnt = '0;
        end else if (st_r.clr_cnt != CLR_CYC) begin
            st_nxt.clr_cnt = st_r.clr_cnt + 23'h0001;
        end

        // overload accumulator: a clear never zeroes it, only decay without excess or reset
        if (overload_excess && st_r.ovl_acc != 16'hffff) begin
            st_nxt.ovl_acc = st_r.ovl_acc + 16'h0001;
        end else if (!overload_excess && st_r.ovl_acc != 16'h0000) begin
            st_nxt.ovl_acc = st_r.ovl_acc - 16'h0001;
        end

        // time since an overload fault was latched
        if (st_r.active && st_r.code.main == MAIN_OVERLOAD && st_r.ovl_cnt != OVL_CYC) begin
            st_nxt.ovl_cnt = st_r.ovl_cnt + 29'h0000_0001;
        end

        // clear: refused when locked or overload wait not over
        if (clr_fire && st_r.active && !st_r.locked && ovl_ok) begin
            st_nxt.active = 1'b0;
            st_nxt.imm = 1'b0;
            st_nxt.irq_stat[IRQ_BIT_CLEARED] = 1'b1;
        end

        // fault capture; the first fault owns the display
        if (fault_valid) begin
            if (in_attr.hist) begin
                st_nxt.hist[st_r.hist_ptr] = fault_code;
                st_nxt.hist_ptr = st_r.hist_ptr + 3'h1;
                if (st_r.hist_cnt != 4'(HIST_DEPTH)) begin
                    st_nxt.hist_cnt = st_r.hist_cnt + 4'h1;
                end
            end
            if (!st_nxt.active) begin
                st_nxt.active = 1'b1;
                st_nxt.code = fault_code;
                st_nxt.locked = !in_attr.clr;
                st_nxt.imm = in_attr.imm;
                st_nxt.ovl_cnt = '0;
            end else if (!in_attr.clr) begin
                // a later permanent fault still pins the error
                st_nxt.locked = 1'b1;
            end
            st_nxt.irq_stat[IRQ_BIT_FAULT] = 1'b1;
        end
        if (!st_nxt.active) begin
            st_nxt.locked = 1'b0;
        end

        // enable follows the host only with no fault pending
        st_nxt.drive_en = st_r.en_f && !st_nxt.active;

        // avalon slave: one wait state, answer on the second cycle
        if (req && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.rdata = '0;
            if (avs_read) begin
                if (avs_address == OFS_CTRL) begin
                    st_nxt.rdata[0] = st_r.ctrl_seq;
                end else if (avs_address == OFS_STATUS) begin
                    st_nxt.rdata[ST_BIT_ACTIVE] = st_r.active;
                    st_nxt.rdata[ST_BIT_LOCKED] = st_r.locked;
                    st_nxt.rdata[ST_BIT_OVL_OK] = ovl_ok;
                    st_nxt.rdata[ST_SUB_LSB +: 8] = st_r.code.sub;
                    st_nxt.rdata[ST_MAIN_LSB +: 8] = st_r.code.main;
                end else if (avs_address == OFS_IRQ_STAT) begin
                    st_nxt.rdata[1:0] = st_r.irq_stat;
                end else if (avs_address == OFS_IRQ_MASK) begin
                    st_nxt.rdata[1:0] = st_r.irq_mask;
                end else if (avs_address == OFS_OVL_ACC) begin
                    st_nxt.rdata[15:0] = st_r.ovl_acc;
                end else if (avs_address == OFS_HIST_CNT) begin
                    st_nxt.rdata[3:0] = st_r.hist_cnt;
                    st_nxt.rdata[10:8] = st_r.hist_ptr;
                end else if (avs_address >= OFS_HIST_BASE) begin
                    st_nxt.rdata[15:0] = st_r.hist[avs_address[4:2]];
                end
            end
        end
        // write and read-clear act at the edge waitrequest is low
        if (st_r.ack && avs_write) begin
            if (avs_address == OFS_CTRL) begin
                st_nxt.ctrl_seq = avs_writedata[0];
            end else if (avs_address == OFS_IRQ_MASK) begin
                st_nxt.irq_mask = avs_writedata[1:0];
            end
        end
        if (st_r.ack && avs_read && avs_address == OFS_IRQ_STAT) begin
            // only bits the read reported are dropped, so an event
            // between the two bus cycles is not lost; set still wins
            st_nxt.irq_stat = (st_r.irq_stat & ~st_r.rdata[1:0])
                | {clr_fire && st_r.active && !st_r.locked && ovl_ok, fault_valid};
        end
    end

    //--------------------------------------------------------------------------
    // state register
    //--------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.ctrl_seq <= CTRL_RST;
            st_r.irq_mask <= IRQ_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    // fault output closed (high) only while no error is latched
    assign fault_output = !st_r.active;
    assign motor_stop = st_r.active;
    assign immediate_stop = st_r.active && st_r.imm && st_r.ctrl_seq;
    assign drive_enable = st_r.drive_en;
    assign display_code = st_r.active ? st_r.code : '0;
    assign irq = |(st_r.irq_stat & st_r.irq_mask);
    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = req && !st_r.ack;

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // any fault opens the output next cycle
    property p_fault_open;
        fault_valid |=> !fault_output && motor_stop;
    endproperty
    a_fault_open: assert property (p_fault_open) else $error("fault did not open output");

    // first fault's code goes to the display
    property p_display;
        fault_valid && !st_r.active && !clr_fire |=> display_code == $past(fault_code);
    endproperty
    a_display: assert property (p_display) else $error("display not showing code");

    // no enable while an error is latched
    property p_no_enable;
        st_r.active |-> !drive_enable;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("drive enabled during fault");

    // clear only after a full hold
    property p_clr_hold;
        $fell(st_r.active) |-> $past(st_r.clr_cnt) == CLR_CYC - 23'h0001 && $past(st_r.clr_f);
    endproperty
    fault_clear_input_hold: assert property (p_clr_hold) else $error("clear without full hold");

    // overload waits its full delay
    property p_ovl_wait;
        $fell(st_r.active) && $past(st_r.code.main) == MAIN_OVERLOAD |-> $past(st_r.ovl_cnt) == OVL_CYC;
    endproperty
    a_ovl_wait: assert property (p_ovl_wait) else $error("overload cleared too early");

    // clear leaves the overload state intact
    property p_ovl_keep;
        $fell(st_r.active) && $past(st_r.ovl_acc) > 16'h0001 |-> st_r.ovl_acc != 16'h0000;
    endproperty
    a_ovl_keep: assert property (p_ovl_keep) else $error("overload state lost on clear");

    // logged entry lands at the write pointer
    property p_hist;
        fault_valid && in_attr.hist |=> st_r.hist_ptr == $past(st_r.hist_ptr) + 3'h1
            && st_r.hist[$past(st_r.hist_ptr)] == $past(fault_code);
    endproperty
    a_hist: assert property (p_hist) else $error("history entry missing");

    // a locked error outlasts any press
    property p_locked;
        st_r.locked |=> st_r.active [*8];
    endproperty
    a_locked: assert property (p_locked) else $error("permanent fault was cleared");

    // immediate stop needs the sequence bit
    property p_imm;
        immediate_stop |-> st_r.ctrl_seq && st_r.imm && motor_stop;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate stop without setting");

    // recognition faults lock and skip history
    property p_recog;
        fault_valid && fault_code.main == MAIN_MOTOR_RECOG && !st_r.active
            |=> st_r.locked && st_r.hist_cnt == $past(st_r.hist_cnt);
    endproperty
    a_recog: assert property (p_recog) else $error("recognition fault misclassified");

    // single wait state on every access
    property p_answer;
        req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");

    // no enable once a fault has been taken
    property p_fault_no_en;
        fault_valid |=> !drive_enable;
    endproperty
    a_fault_no_en: assert property (p_fault_no_en) else $error("enable after fault");

    // sequence bit off keeps immediate stop off
    property p_imm_sel;
        !st_r.ctrl_seq |-> !immediate_stop;
    endproperty
    a_imm_sel: assert property (p_imm_sel) else $error("immediate stop not selected");

    // one press fires the clear only once
    property p_one_clear;
        clr_fire |=> !clr_fire [*8];
    endproperty
    a_one_clear: assert property (p_one_clear) else $error("second clear in one press");

    // a locked error ignores a full press
    property p_locked_refuse;
        clr_fire && st_r.locked |=> st_r.active;
    endproperty
    a_locked_refuse: assert property (p_locked_refuse) else $error("locked error cleared");

    // early press on overload is refused
    property p_ovl_early;
        clr_fire && st_r.active && st_r.code.main == MAIN_OVERLOAD && st_r.ovl_cnt != OVL_CYC |=> st_r.active;
    endproperty
    a_ovl_early: assert property (p_ovl_early) else $error("overload early clear");

    // codes without history leave the log alone
    property p_hist_skip;
        fault_valid && !in_attr.hist |=> st_r.hist_ptr == $past(st_r.hist_ptr);
    endproperty
    a_hist_skip: assert property (p_hist_skip) else $error("entry logged without history");

    // display steady while the error stands
    property p_display_hold;
        st_r.active && !clr_fire |=> display_code == $past(display_code);
    endproperty
    a_display_hold: assert property (p_display_hold) else $error("display changed");

    // idle outputs with no error latched
    property p_out_idle;
        !st_r.active |-> fault_output && !motor_stop && !immediate_stop && display_code == '0;
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("fault outputs without error");

    // fault flag set even against a read-clear
    property p_irq_set;
        fault_valid |=> st_r.irq_stat[IRQ_BIT_FAULT];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("fault flag lost");

    // accepted clear raises its flag
    property p_clr_flag;
        clr_fire && st_r.active && !st_r.locked && ovl_ok |=> st_r.irq_stat[IRQ_BIT_CLEARED];
    endproperty
    fault_clear_input_flag: assert property (p_clr_flag) else $error("clear flag lost");

    // accumulator climbs while overloaded
    property p_acc_rise;
        overload_excess && st_r.ovl_acc != 16'hffff |=> st_r.ovl_acc == $past(st_r.ovl_acc) + 16'h0001;
    endproperty
    a_acc_rise: assert property (p_acc_rise) else $error("overload state not rising");

    // accumulator decays when load drops
    property p_acc_fall;
        !overload_excess && st_r.ovl_acc != 16'h0000 |=> st_r.ovl_acc == $past(st_r.ovl_acc) - 16'h0001;
    endproperty
    a_acc_fall: assert property (p_acc_fall) else $error("overload state not falling");

    // locked stays until power goes
    property p_locked_stay;
        st_r.locked |=> st_r.locked;
    endproperty
    a_locked_stay: assert property (p_locked_stay) else $error("lock dropped");

    // sequence bit takes the written value
    property p_ctrl_write;
        avs_write && !avs_waitrequest && avs_address == OFS_CTRL |=> st_r.ctrl_seq == $past(avs_writedata[0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("sequence bit not written");

    // read data stands after the answer
    property p_rd_stand;
        req && !avs_waitrequest |=> avs_readdata == $past(avs_readdata);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data changed");

    // host enable passes with no error
    property p_en_free;
        !st_r.active && st_r.en_f && !fault_valid |=> drive_enable;
    endproperty
    a_en_free: assert property (p_en_free) else $error("enable withheld without fault");

    c_fault_clear: cover property (st_r.active ##1 !st_r.active);
    c_ovl_clear: cover property ($fell(st_r.active) && $past(st_r.code.main) == MAIN_OVERLOAD);
    c_locked: cover property (st_r.locked && clr_fire);
    c_imm: cover property (immediate_stop);
    c_no_hist: cover property (fault_valid && !in_attr.hist);
endmodule
`default_nettype wire

// ===== sim/sfm_host_model.sv
// host controller model: drives the fault clear and drive enable pins
`timescale 1ns/10ps
`default_nettype none
module sfm_host_model (
    input wire logic clk,
    input wire logic motor_stop,
    output logic fault_clear_input,
    output logic drive_enable_req
);
    // ------------------------------------------------------------------
    // pin levels at power up
    // ------------------------------------------------------------------
    initial begin
        fault_clear_input = 1'b0;
        drive_enable_req = 1'b1;
    end

    // clear pulse of n cycles if motor_stop is high at the start; enable dropped on the same edge and withheld for the pulse
    task automatic hold_clear(input int n);
        @(posedge clk);
        drive_enable_req <= 1'b0;
        if (motor_stop === 1'b1) begin
            fault_clear_input <= 1'b1;
        end
        repeat (n) @(posedge clk);
        fault_clear_input <= 1'b0;
        drive_enable_req <= 1'b1;
        // long idle so the pin filter surely sees the release
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== sim/sfm_fault_manager_tb.sv
// testbench: fault codes, clearing, overload wait and registers of the fault manager
`timescale 1ns/10ps
`default_nettype none
module sfm_fault_manager_tb;
    import sfm_pkg::*;
    localparam int CLR = 20;
    localparam int LIMIT = 8000;
    typedef struct packed {
        sfm_code_t c;
        logic h;
        logic cl;
        logic im;
    } sfm_row_t;
    logic clk, rst_b, fault_valid, overload_excess, fault_clear_input, drive_enable_req;
    logic fault_output, motor_stop, immediate_stop, drive_enable, irq;
    logic avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, p;
    sfm_code_t fault_code, display_code;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    // code, history, clearable, immediate stop
    sfm_row_t rows [13] = '{
        '{16'h0b00, 1'b0, 1'b1, 1'b0}, '{16'h0c00, 1'b1, 1'b1, 1'b0}, '{16'h0d01, 1'b0, 1'b1, 1'b0},
        '{16'h1501, 1'b1, 1'b0, 1'b0}, '{16'h1700, 1'b1, 1'b0, 1'b0},
        '{16'h1b02, 1'b1, 1'b1, 1'b1}, '{16'h1c00, 1'b1, 1'b1, 1'b1},
        '{16'h2107, 1'b1, 1'b0, 1'b0},
        '{16'h2800, 1'b1, 1'b1, 1'b0}, '{16'h2f00, 1'b1, 1'b0, 1'b0},
        '{16'h3305, 1'b1, 1'b0, 1'b0}, '{16'h3702, 1'b1, 1'b0, 1'b0},
        '{16'h5f04, 1'b0, 1'b0, 1'b0}};

    // ------------------------------------------------------------------
    // clock, device and host
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    sfm_fault_manager #(.CLR_CYC(23'(CLR)), .OVL_CYC(29'h32)) i_dut (.clk(clk), .rst_b(rst_b),
        .fault_valid(fault_valid), .fault_code(fault_code), .overload_excess(overload_excess),
        .fault_clear_input(fault_clear_input), .drive_enable_req(drive_enable_req),
        .fault_output(fault_output), .motor_stop(motor_stop), .immediate_stop(immediate_stop),
        .drive_enable(drive_enable), .display_code(display_code), .irq(irq), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    sfm_host_model host (.clk(clk), .motor_stop(motor_stop), .fault_clear_input(fault_clear_input),
        .drive_enable_req(drive_enable_req));

    // ------------------------------------------------------------------
    // verdict, hang guard, compares and drivers
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // a stuck handshake or wait ends here rather than hanging the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic chk_pin(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        // looked at mid-cycle: the level the next rising edge samples
        @(negedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(negedge clk);
        end
        r = avs_readdata;
        @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic inject(input sfm_code_t c);
        @(posedge clk);
        fault_valid <= 1'b1;
        fault_code <= c;
        @(posedge clk);
        fault_valid <= 1'b0;
    endtask
    task automatic power_cycle();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        fault_valid = 1'b0;
        fault_code = 16'h0000;
        overload_excess = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        power_cycle();
        repeat (8) @(posedge clk);
        #1;
        chk_pin(fault_output, 1'b1);
        chk_pin(drive_enable, 1'b1);
        bus(1'b0, OFS_CTRL, 32'h0000_0000, q);
        chk_word(q, 32'h0000_0000);
        bus(1'b0, OFS_IRQ_MASK, 32'h0000_0000, q);
        chk_word(q, 32'h0000_0000);
        bus(1'b0, 6'h18, 32'h0000_0000, q);
        chk_word(q, 32'h0000_0000);
        // ordinary cases: every listed code raised, then a full clear tried
        for (int i = 0; i < 13; i++) begin
            power_cycle();
            bus(1'b1, OFS_CTRL, {31'h0, i[0]}, q);
            bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001, q);
            inject(rows[i].c);
            #1;
            chk_pin(fault_output, 1'b0);
            chk_pin(motor_stop, 1'b1);
            chk_word({16'h0000, display_code}, {16'h0000, rows[i].c});
            chk_pin(immediate_stop, rows[i].im & i[0]);
            chk_pin(irq, 1'b1);
            bus(1'b0, OFS_HIST_CNT, 32'h0000_0000, q);
            chk_word({28'h0, q[3:0]}, {31'h0, rows[i].h});
            bus(1'b0, OFS_HIST_BASE, 32'h0000_0000, q);
            chk_word({16'h0000, q[15:0]}, rows[i].h ? {16'h0000, rows[i].c} : 32'h0000_0000);
            bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
            chk_word(q, {8'h00, rows[i].c, 5'h00, 1'b1, ~rows[i].cl, 1'b1});
            #1;
            chk_pin(drive_enable, 1'b0);
            host.hold_clear(CLR + 8);
            #1;
            chk_pin(fault_output, rows[i].cl);
            chk_pin(drive_enable, rows[i].cl);
            bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000, q);
            chk_word(q, {30'h0, rows[i].cl, 1'b1});
            @(posedge clk);
            #1;
            chk_pin(irq, 1'b0);
        end
        // short pulse refused, then a full one clears
        power_cycle();
        inject(16'h0c00);
        host.hold_clear(CLR - 8);
        #1;
        chk_pin(fault_output, 1'b0);
        host.hold_clear(CLR + 8);
        #1;
        chk_pin(fault_output, 1'b1);
        // a fault raised late in one long press outlives that press
        inject(16'h0c00);
        fork
            host.hold_clear(CLR + 40);
            begin
                repeat (CLR + 12) @(posedge clk);
                inject(16'h0c00);
            end
        join
        #1;
        chk_pin(fault_output, 1'b0);
        // a later non-clearable fault locks the first one in place
        power_cycle();
        inject(16'h0c00);
        inject(16'h1501);
        host.hold_clear(CLR + 8);
        #1;
        chk_pin(fault_output, 1'b0);
        chk_word({16'h0000, display_code}, 32'h0000_0c00);
        // overload: early clear refused, late clear accepted, accumulator kept
        power_cycle();
        @(posedge clk);
        overload_excess <= 1'b1;
        inject(16'h1000);
        host.hold_clear(CLR + 8);
        #1;
        chk_pin(fault_output, 1'b0);
        bus(1'b0, OFS_OVL_ACC, 32'h0000_0000, p);
        host.hold_clear(CLR + 8);
        #1;
        chk_pin(fault_output, 1'b1);
        bus(1'b0, OFS_OVL_ACC, 32'h0000_0000, q);
        chk_pin(q[15:0] != 16'h0000, 1'b1);
        // still climbing past the pre-clear value: the clear did not zero it
        chk_pin(q[15:0] > p[15:0], 1'b1);
        @(posedge clk);
        overload_excess <= 1'b0;
        repeat (4) @(posedge clk);
        power_cycle();
        bus(1'b0, OFS_OVL_ACC, 32'h0000_0000, q);
        chk_word(q, 32'h0000_0000);
        stop_test();
    end
endmodule
`default_nettype wire
